//--- design/itm_cfg.svh
// Purpose: Constants for the three-channel interval timer with read-back.
// Assumes: Included by the package and the timer module.
// Notes:   Field positions are bit indices of the setup word.
// What this block does
// RULE1 - A setup word sets load-pending only on the counter it selects.
// RULE2 - A count write sets load-pending; two-byte counts only on the second byte.
// RULE3 - Repeated status latch before a read is ignored; first status is kept.
// RULE4 - Read-back with bits 5 and 4 low latches count and status separately.
// RULE5 - With both latched, first read gives status, then count, then live count.
// RULE6 - Write strobe: port select 00 to 10 writes counters, 11 the setup word.
// RULE7 - Read strobe: 00 to 10 reads counters; anything else releases the bus.
// RULE8 - A clock pulse is a rising then a falling edge of the counter clock.
// RULE9 - A trigger is a rising edge of the count-enable input.
// RULE10 - Mode 0: pin low after setup word, high at zero until rewritten.
// RULE11 - Mode 0: enable high counts, low suspends; it never moves the pin.
// RULE12 - Mode 0: first pulse loads without decrement; pin high N+1 pulses on.
// RULE13 - Mode 0: a new count loads on the next pulse and counting resumes.
// RULE14 - Mode 0 two-byte: first byte suspends counting and drives the pin low.
// RULE15 - Mode 0 two-byte: second byte lets the count load on the next pulse.
// RULE16 - Mode 0: count loads even with enable low; high N pulses after enable.
// RULE17 - Mode 1: pin high, low the pulse after a trigger, high again at zero.
// RULE18 - Mode 1: writes only arm; each trigger loads and starts an N pulse.
// RULE19 - Mode 1: retriggerable; enable level otherwise never moves the pin.
// RULE20 - Mode 1: a new count waits for a retrigger before it takes effect.
// RULE21 - Status byte: pin in bit 7, load-pending in bit 6, mode bits below.
// RULE22 - Read-back bits 3, 2 and 1 select counters 2, 1 and 0.
// RULE23 - Load-pending clears once the latest count enters the counting element.
// RULE24 - Counts load and decrement on the falling edge of the counter clock.
// RULE25 - With nothing latched a read returns the live count in byte order.
`ifndef ITM_CFG_SVH
`define ITM_CFG_SVH
`define ITM_NUM_CTR   3
`define ITM_SEL_SETUP 2'h3
`define ITM_SC_RB     2'h3
`define ITM_RW_LATCH  2'h0
`define ITM_RW_LSB    2'h1
`define ITM_RW_MSB    2'h2
`define ITM_RW_BOTH   2'h3
`define ITM_MODE0     3'h0
`define ITM_MODE1     3'h1
`define ITM_RB_NOCNT  5
`define ITM_RB_NOSTAT 4
`define ITM_CTL_RST   6'h00
`define ITM_CNT_RST   16'h0000
`define ITM_CNT_ONE   16'h0001
`endif

//--- design/itm_pkg.sv
// Purpose: Types shared by the interval timer design.
// Assumes: Constants come from itm_cfg.svh.
// Notes:   Bus pins travel together as one packed struct.
`include "itm_cfg.svh"
package itm_pkg;
   // Host bus strobes and port select, all active as documented on the pins.
   typedef struct packed {
      logic       cs_n;
      logic       rd_n;
      logic       wr_n;
      logic       port_select_hi;
      logic       port_select_lo;
   } itm_bus_t;
   typedef logic [15:0] itm_count_t;
   // Byte phase of a two-byte transfer.
   typedef enum logic {
      ITM_PH_LSB,
      ITM_PH_MSB
   } itm_phase_t;
endpackage : itm_pkg

//--- design/itm_top.sv
// Purpose: Three 16-bit counters, modes 0 and 1, latches and read-back.
// Assumes: All pins are asynchronous to clk_i and are synchronised here.
// Notes:   Modes other than 0 and 1 count with the enable and hold the pin high.
`timescale 1ns/1ps
`include "itm_cfg.svh"
module itm_top (
   input  wire logic                 clk_i,
   input  wire logic                 reset_n_i,
   input  wire itm_pkg::itm_bus_t    bus_i,
   input  wire logic [7:0]           data_i,
   output logic [7:0]                data_o,
   output logic                      data_oe_o,
   input  wire logic [2:0]           ctr_clk_i,
   input  wire logic [2:0]           ctr_en_i,
   output logic [2:0]                ctr_pulse_o
);
   import itm_pkg::*;

   // =======================================================
   // Functions
   // =======================================================

   // Decrements by one in binary or in four BCD digits, wrapping at zero.
   function automatic itm_count_t itm_dec(input itm_count_t v, input logic bcd);
      itm_count_t r;
      logic       brw;
      r   = v;
      brw = 1'b1;
      if (!bcd) begin
         r = v - `ITM_CNT_ONE;
      end else begin
         for (int i = 0; i < 4; i++) begin
            if (brw) begin
               if (r[4*i +: 4] == 4'h0) begin
                  r[4*i +: 4] = 4'h9;
               end else begin
                  r[4*i +: 4] = r[4*i +: 4] - 4'h1;
                  brw         = 1'b0;
               end
            end
         end
      end
      return r;
   endfunction : itm_dec

   // Picks the byte a read returns: status first, else count by format.
   function automatic logic [7:0] itm_rd_byte(input logic       st_lat,
                                              input logic [7:0] st,
                                              input itm_count_t val,
                                              input logic [1:0] rw,
                                              input itm_phase_t ph);
      logic [7:0] b;
      b = val[7:0];
      if (st_lat) begin
         b = st; // RULE5
      end else if (rw == `ITM_RW_MSB) begin
         b = val[15:8];
      end else if (rw == `ITM_RW_BOTH && ph == ITM_PH_MSB) begin
         b = val[15:8];
      end
      return b;
   endfunction : itm_rd_byte

   // =======================================================
   // Synchronisers
   // =======================================================

   itm_bus_t   bus_s1;
   itm_bus_t   bus_s2;
   logic [7:0] dat_s1;
   logic [7:0] dat_s2;
   logic [2:0] cclk_s1;
   logic [2:0] cclk_s2;
   logic [2:0] cclk_d;
   logic [2:0] gate_s1;
   logic [2:0] gate_s2;
   logic [2:0] gate_d;

   // Two flops on every pin; clock and enable start high so no false rise follows reset.
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         bus_s1  <= '1;
         bus_s2  <= '1;
         dat_s1  <= 8'h00;
         dat_s2  <= 8'h00;
         cclk_s1 <= 3'h7;
         cclk_s2 <= 3'h7;
         cclk_d  <= 3'h7;
         gate_s1 <= 3'h7;
         gate_s2 <= 3'h7;
         gate_d  <= 3'h7;
      end else begin
         bus_s1  <= bus_i;
         bus_s2  <= bus_s1;
         dat_s1  <= data_i;
         dat_s2  <= dat_s1;
         cclk_s1 <= ctr_clk_i;
         cclk_s2 <= cclk_s1;
         cclk_d  <= cclk_s2;
         gate_s1 <= ctr_en_i;
         gate_s2 <= gate_s1;
         gate_d  <= gate_s2;
      end
   end

   // =======================================================
   // Counter clock pulses and triggers
   // =======================================================

   logic [2:0] cclk_rise;
   logic [2:0] cclk_fall;
   logic [2:0] half_r;
   logic [2:0] pulse_evt;
   logic [2:0] gate_hi_r;
   logic [2:0] trig_r;

   // Edges of the synchronised counter clock and enable.
   assign cclk_rise = cclk_s2 & ~cclk_d;
   assign cclk_fall = ~cclk_s2 & cclk_d;
   assign pulse_evt = cclk_fall & half_r; // RULE8

   // Remembers a rising edge so that only a following fall counts as a pulse.
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         half_r <= 3'h0;
      end else begin
         half_r <= (half_r | cclk_rise) & ~cclk_fall; // RULE8
      end
   end

   // Enable level is sampled on the rising edge of the counter clock.
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         gate_hi_r <= 3'h0;
      end else begin
         for (int c = 0; c < `ITM_NUM_CTR; c++) begin
            if (cclk_rise[c]) begin
               gate_hi_r[c] <= gate_s2[c];
            end
         end
      end
   end

   // Trigger flag: set by an enable rise, consumed by the next pulse.
   // A rise in the consuming cycle is kept, so no trigger is lost.
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         trig_r <= 3'h0;
      end else begin
         trig_r <= (trig_r & ~pulse_evt) | (gate_s2 & ~gate_d); // RULE9
      end
   end

   // =======================================================
   // Host bus decode
   // =======================================================

   logic       wr_act;
   logic       rd_act;
   logic       wr_prev_r;
   logic       rd_prev_r;
   logic [1:0] wsel_r;
   logic [7:0] wdat_r;
   logic [1:0] rsel_r;
   logic       wr_evt;
   logic       rd_evt;
   logic [1:0] sel_s;

   assign sel_s = {bus_s2.port_select_hi, bus_s2.port_select_lo};

   // Write needs read strobe high; read needs a counter port.
   assign wr_act = ~bus_s2.cs_n & bus_s2.rd_n & ~bus_s2.wr_n; // RULE6
   assign rd_act = ~bus_s2.cs_n & ~bus_s2.rd_n & bus_s2.wr_n
                   & (sel_s != `ITM_SEL_SETUP); // RULE7

   // An access acts when its strobe ends, using what was held while active.
   assign wr_evt = wr_prev_r & ~wr_act;
   assign rd_evt = rd_prev_r & ~rd_act;

   // Captures select and data during the strobe.
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         wr_prev_r <= 1'b0;
         rd_prev_r <= 1'b0;
         wsel_r    <= 2'h0;
         wdat_r    <= 8'h00;
         rsel_r    <= 2'h0;
      end else begin
         wr_prev_r <= wr_act;
         rd_prev_r <= rd_act;
         if (wr_act) begin
            wsel_r <= sel_s;
            wdat_r <= dat_s2;
         end
         if (rd_act) begin
            rsel_r <= sel_s;
         end
      end
   end

   // =======================================================
   // Counter state
   // =======================================================

   logic [5:0]  ctl_r   [3];
   itm_count_t  cr_r    [3];
   itm_count_t  ce_r    [3];
   itm_count_t  ol_r    [3];
   logic [7:0]  st_r    [3];
   itm_phase_t  wph_r   [3];
   itm_phase_t  rph_r   [3];
   logic [2:0]  cnt_lat_r;
   logic [2:0]  st_lat_r;
   logic [2:0]  null_r;
   logic [2:0]  out_r;
   logic [2:0]  hold_r;
   logic [2:0]  loaded_r;

   // Pulses, then host writes, then reads; later updates win in a cycle.
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         for (int c = 0; c < `ITM_NUM_CTR; c++) begin
            ctl_r[c] <= `ITM_CTL_RST;
            cr_r[c]  <= `ITM_CNT_RST;
            ce_r[c]  <= `ITM_CNT_RST;
            ol_r[c]  <= `ITM_CNT_RST;
            st_r[c]  <= 8'h00;
            wph_r[c] <= ITM_PH_LSB;
            rph_r[c] <= ITM_PH_LSB;
         end
         cnt_lat_r <= 3'h0;
         st_lat_r  <= 3'h0;
         null_r    <= 3'h0;
         out_r     <= 3'h0;
         hold_r    <= 3'h0;
         loaded_r  <= 3'h0;
      end else begin
         for (int c = 0; c < `ITM_NUM_CTR; c++) begin
            itm_count_t nxt;
            logic       m0;
            nxt = itm_dec(ce_r[c], ctl_r[c][0]);
            m0  = (ctl_r[c][3:1] == `ITM_MODE0);
            // Counting on a clock pulse, at its falling edge.
            if (pulse_evt[c]) begin // RULE24
               if (ctl_r[c][3:1] == `ITM_MODE1) begin
                  if (trig_r[c]) begin
                     ce_r[c]     <= cr_r[c]; // RULE18 RULE20
                     null_r[c]   <= 1'b0; // RULE23
                     out_r[c]    <= 1'b0; // RULE17
                     loaded_r[c] <= 1'b1; // RULE19
                  end else if (loaded_r[c]) begin
                     ce_r[c] <= nxt;
                     if (nxt == `ITM_CNT_RST) begin
                        out_r[c] <= 1'b1; // RULE17
                     end
                  end
               end else if (null_r[c] && !hold_r[c]) begin
                  ce_r[c]     <= cr_r[c]; // RULE12
                  null_r[c]   <= 1'b0; // RULE23
                  loaded_r[c] <= 1'b1; // RULE16
               end else if (loaded_r[c] && !hold_r[c] && gate_hi_r[c]) begin
                  ce_r[c] <= nxt; // RULE11
                  if (nxt == `ITM_CNT_RST) begin
                     out_r[c] <= 1'b1; // RULE10
                  end
               end
            end
            // Setup word and read-back commands.
            if (wr_evt && wsel_r == `ITM_SEL_SETUP) begin
               if (wdat_r[7:6] == `ITM_SC_RB) begin
                  if (wdat_r[c+1]) begin // RULE22
                     if (!wdat_r[`ITM_RB_NOCNT] && !cnt_lat_r[c]) begin
                        ol_r[c]      <= ce_r[c]; // RULE4
                        cnt_lat_r[c] <= 1'b1;
                     end
                     if (!wdat_r[`ITM_RB_NOSTAT] && !st_lat_r[c]) begin
                        st_r[c]     <= {out_r[c], null_r[c], ctl_r[c]}; // RULE21
                        st_lat_r[c] <= 1'b1; // RULE3
                     end
                  end
               end else if (wdat_r[7:6] == 2'(c)) begin
                  if (wdat_r[5:4] == `ITM_RW_LATCH) begin
                     if (!cnt_lat_r[c]) begin
                        ol_r[c]      <= ce_r[c];
                        cnt_lat_r[c] <= 1'b1;
                     end
                  end else begin
                     ctl_r[c]     <= wdat_r[5:0];
                     null_r[c]    <= 1'b1; // RULE1
                     out_r[c]     <= (wdat_r[3:1] != `ITM_MODE0); // RULE10
                     wph_r[c]     <= ITM_PH_LSB;
                     rph_r[c]     <= ITM_PH_LSB;
                     cnt_lat_r[c] <= 1'b0;
                     st_lat_r[c]  <= 1'b0;
                     hold_r[c]    <= 1'b1; // RULE23
                     loaded_r[c]  <= 1'b0;
                  end
               end
            end
            // Count writes in the programmed byte format.
            if (wr_evt && wsel_r == 2'(c)) begin
               if (ctl_r[c][5:4] == `ITM_RW_LSB) begin
                  cr_r[c]   <= {8'h00, wdat_r};
                  null_r[c] <= 1'b1; // RULE2
                  hold_r[c] <= 1'b0; // RULE12
                  if (m0) begin
                     out_r[c] <= 1'b0; // RULE13
                  end
               end else if (ctl_r[c][5:4] == `ITM_RW_MSB) begin
                  cr_r[c]   <= {wdat_r, 8'h00};
                  null_r[c] <= 1'b1; // RULE2
                  hold_r[c] <= 1'b0; // RULE12
                  if (m0) begin
                     out_r[c] <= 1'b0; // RULE13
                  end
               end else if (ctl_r[c][5:4] == `ITM_RW_BOTH) begin
                  if (wph_r[c] == ITM_PH_LSB) begin
                     cr_r[c][7:0] <= wdat_r;
                     wph_r[c]     <= ITM_PH_MSB;
                     if (m0) begin
                        hold_r[c] <= 1'b1; // RULE14
                        out_r[c]  <= 1'b0; // RULE14
                     end
                  end else begin
                     cr_r[c][15:8] <= wdat_r;
                     wph_r[c]      <= ITM_PH_LSB;
                     null_r[c]     <= 1'b1; // RULE2
                     hold_r[c]     <= 1'b0; // RULE15
                  end
               end
            end
            // A finished read releases the status, then the count bytes.
            if (rd_evt && rsel_r == 2'(c)) begin
               if (st_lat_r[c]) begin
                  st_lat_r[c] <= 1'b0; // RULE5
               end else if (ctl_r[c][5:4] == `ITM_RW_BOTH
                            && rph_r[c] == ITM_PH_LSB) begin
                  rph_r[c] <= ITM_PH_MSB;
               end else begin
                  rph_r[c]     <= ITM_PH_LSB;
                  cnt_lat_r[c] <= 1'b0; // RULE5
               end
            end
         end
      end
   end

   // =======================================================
   // Read data and pins
   // =======================================================

   logic [7:0] rd_byte;
   itm_count_t rd_val;
   logic [1:0] ri;

   // Selects the addressed counter; the setup port selects counter 0.
   always_comb begin
      ri      = (sel_s == `ITM_SEL_SETUP) ? 2'h0 : sel_s;
      rd_val  = cnt_lat_r[ri] ? ol_r[ri] : ce_r[ri]; // RULE25
      rd_byte = itm_rd_byte(st_lat_r[ri], st_r[ri], rd_val,
                            ctl_r[ri][5:4], rph_r[ri]);
   end

   // Read data is registered every cycle, whether the bus is idle, reading or writing.
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         data_o <= 8'h00;
      end else begin
         data_o <= rd_byte;
      end
   end

   assign data_oe_o   = rd_act; // RULE7
   assign ctr_pulse_o = out_r;

endmodule : itm_top

//--- tb/itm_host.sv
// Purpose: Host processor model that drives the timer's parallel bus.
// Assumes: Every task is entered just after a rising edge of clk_i.
// Notes:   Strobes are held 5 clk, then the bus idles 5 clk.
`timescale 1ns/1ps
module itm_host (
   input  wire logic              clk_i,
   input  wire logic [7:0]        rd_data_i,
   input  wire logic              oe_i,
   output itm_pkg::itm_bus_t      bus_o,
   output logic [7:0]             wr_data_o
);
   import itm_pkg::*;
   // ==========================================================
   // Bus cycles
   // The bus starts idle with chip select and both strobes high.
   initial begin
      bus_o     = 5'h1c;
      wr_data_o = 8'h00;
   end
   // Write: port select and data stay put until the strobe has ended.
   task automatic wr(input logic [1:0] sel, input logic [7:0] val);
      bus_o     <= {3'h2, sel};
      wr_data_o <= val;
      repeat (5) @(posedge clk_i);
      bus_o     <= 5'h1c;
      wr_data_o <= ~val;
      repeat (5) @(posedge clk_i);
   endtask : wr
   // Read: the byte and the enable are taken at the last edge of the strobe.
   task automatic rd(input logic [1:0] sel, input logic cs_n,
                     output logic [7:0] val, output logic oe);
      bus_o <= {cs_n, 2'h1, sel};
      repeat (5) @(posedge clk_i);
      val   = rd_data_i;
      oe    = oe_i;
      bus_o <= 5'h1c;
      repeat (5) @(posedge clk_i);
   endtask : rd
endmodule : itm_host

//--- tb/itm_sva.sv
// Purpose: Port-level checks of the interval timer.
// Assumes: Bound to itm_top; all pins seen on clk_i.
// Notes:   Ages count clk cycles since a counter clock fall or a write.
`timescale 1ns/1ps
module itm_sva (
   input  wire logic              clk_i,
   input  wire logic              reset_n_i,
   input  wire itm_pkg::itm_bus_t bus_i,
   input  wire logic [7:0]        data_i,
   input  wire logic [7:0]        data_o,
   input  wire logic              data_oe_o,
   input  wire logic [2:0]        ctr_clk_i,
   input  wire logic [2:0]        ctr_en_i,
   input  wire logic [2:0]        ctr_pulse_o
);
   import itm_pkg::*;
   logic       rd_ok;
   logic       wr_ok;
   logic       calm;
   logic [2:0] clk_q_r;
   logic [3:0] wr_age_r;
   logic [3:0] fall_age_r [3];
   default clocking @(posedge clk_i); endclocking
   default disable iff (!reset_n_i);
   // ==========================================================
   // Helpers
   // Decoded strobe combinations and a flag for no recent counter fall.
   assign rd_ok = !bus_i.cs_n && !bus_i.rd_n && bus_i.wr_n
                  && !(bus_i.port_select_hi && bus_i.port_select_lo);
   assign wr_ok = !bus_i.cs_n && bus_i.rd_n && !bus_i.wr_n;
   assign calm  = fall_age_r[0] > 4'h7 && fall_age_r[1] > 4'h7 && fall_age_r[2] > 4'h7;
   // Saturating ages since the last write strobe and each counter clock fall.
   always_ff @(posedge clk_i or negedge reset_n_i) begin
      if (!reset_n_i) begin
         clk_q_r  <= 3'h0;
         wr_age_r <= 4'h0;
         for (int k = 0; k < 3; k++) fall_age_r[k] <= 4'h0;
      end else begin
         clk_q_r  <= ctr_clk_i;
         wr_age_r <= wr_ok ? 4'h0 : wr_age_r + {3'h0, wr_age_r != 4'hf};
         for (int k = 0; k < 3; k++) begin
            fall_age_r[k] <= (clk_q_r[k] && !ctr_clk_i[k]) ? 4'h0
                             : fall_age_r[k] + {3'h0, fall_age_r[k] != 4'hf};
         end
      end
   end
   // ==========================================================
   // Bus assertions
   a_oe_needs_read: assert property (data_oe_o |-> $past(rd_ok, 2) || $past(rd_ok, 3))
      else $error("Data bus driven without a read strobe");
   a_oe_idle_off: assert property ((!rd_ok) [*4] |-> !data_oe_o)
      else $error("Data bus still driven after the read ended");
   a_oe_read_on: assert property (rd_ok [*4] |-> data_oe_o)
      else $error("Data bus not driven during a read");
   a_cs_blocks: assert property (bus_i.cs_n [*4] |-> !data_oe_o)
      else $error("Data bus driven while not selected");
   a_write_no_oe: assert property (wr_ok [*4] |-> !data_oe_o)
      else $error("Data bus driven during a write");
   a_read_steady: assert property ($rose(data_oe_o) && calm ##1 calm [*3] |-> $stable(data_o))
      else $error("Read byte moved while counters were still");
   // ==========================================================
   // Counter pin assertions
   for (genvar k = 0; k < 3; k++) begin : g_pin
      a_pin_cause: assert property ($changed(ctr_pulse_o[k]) |->
                                    fall_age_r[k] < 4'h8 || wr_age_r < 4'h8)
         else $error("Counter pin moved without a clock fall or write");
      a_rise_inert: assert property ($rose(ctr_clk_i[k]) && fall_age_r[k] > 4'h7 &&
                                     wr_age_r > 4'h7 |=> $stable(ctr_pulse_o[k]) [*5])
         else $error("Counter pin moved on a clock rise");
   end
   // Main scenarios seen.
   c_read: cover property ($rose(data_oe_o));
   c_shot: cover property ($fell(ctr_pulse_o[1]));
   c_term: cover property ($rose(ctr_pulse_o[2]));
endmodule : itm_sva
bind itm_top itm_sva u_sva (.clk_i(clk_i), .reset_n_i(reset_n_i), .bus_i(bus_i),
   .data_i(data_i), .data_o(data_o), .data_oe_o(data_oe_o), .ctr_clk_i(ctr_clk_i),
   .ctr_en_i(ctr_en_i), .ctr_pulse_o(ctr_pulse_o));

//--- tb/itm_top_bench.sv
// Purpose: Self-checking bench for the interval timer in modes 0 and 1.
// Assumes: The host model drives the bus; this bench drives counter pins.
// Notes:   Counter clock phases are 4 clk high and 7 clk low.
`timescale 1ns/1ps
module itm_top_bench;
   import itm_pkg::*;
   logic       clk = 1'b0;
   logic       rst_n = 1'b0;
   itm_bus_t   bus;
   logic [7:0] wdata;
   logic [7:0] rdata;
   logic       oe;
   logic [2:0] cclk = 3'h0;
   logic [2:0] en = 3'h5;
   logic [2:0] pin;
   int         fails = 0;
   int         comparisons = 0;
   // ==========================================================
   // Harness
   // Free-running 50 MHz clock.
   always #10 clk = ~clk;
   itm_top dut (.clk_i(clk), .reset_n_i(rst_n), .bus_i(bus), .data_i(wdata),
      .data_o(rdata), .data_oe_o(oe), .ctr_clk_i(cclk), .ctr_en_i(en), .ctr_pulse_o(pin));
   itm_host host (.clk_i(clk), .rd_data_i(rdata), .oe_i(oe), .bus_o(bus), .wr_data_o(wdata));
   // ==========================================================
   // Helpers
   task automatic chk(input logic [7:0] seen, input logic [7:0] exp);
      comparisons++;
      if (seen !== exp) begin
         fails++;
         $display("BAD %0t saw %h want %h", $time, seen, exp);
      end
   endtask : chk
   task automatic cp(input int k, input logic v);
      chk({7'h00, pin[k]}, {7'h00, v});
   endtask : cp
   task automatic rc(input logic [1:0] sel, input logic [7:0] exp);
      logic [7:0] v;
      logic       o;
      host.rd(sel, 1'b0, v, o);
      chk(v, exp);
   endtask : rc
   task automatic pl(input int k, input int n);
      repeat (n) begin
         cclk <= cclk | (3'h1 << k);
         repeat (4) @(posedge clk);
         cclk <= cclk & ~(3'h1 << k);
         repeat (7) @(posedge clk);
      end
   endtask : pl
   task automatic trg(input int k);
      en <= en & ~(3'h1 << k);
      repeat (4) @(posedge clk);
      en <= en | (3'h1 << k);
      repeat (4) @(posedge clk);
   endtask : trg
   // ==========================================================
   // Scenarios
   task automatic t_mode0;
      host.wr(2'h3, 8'h10);
      host.wr(2'h3, 8'he2);
      rc(2'h0, 8'h50);
      host.wr(2'h0, 8'h03);
      pl(0, 1);
      host.wr(2'h3, 8'he2);
      rc(2'h0, 8'h10);
      rc(2'h0, 8'h03);
      pl(0, 2);
      cp(0, 1'b0);
      rc(2'h0, 8'h01);
      pl(0, 1);
      cp(0, 1'b1);
      en[0] <= 1'b0;
      host.wr(2'h0, 8'h02);
      cp(0, 1'b0);
      pl(0, 3);
      cp(0, 1'b0);
      rc(2'h0, 8'h02);
      en[0] <= 1'b1;
      repeat (4) @(posedge clk);
      pl(0, 1);
      cp(0, 1'b0);
      pl(0, 1);
      cp(0, 1'b1);
      $display("t_mode0 done");
   endtask : t_mode0
   task automatic t_flags;
      logic [7:0] v;
      logic       o;
      host.wr(2'h3, 8'h50);
      host.wr(2'h3, 8'he6);
      rc(2'h0, 8'h90);
      rc(2'h1, 8'h50);
      host.wr(2'h3, 8'he2);
      host.wr(2'h0, 8'h05);
      host.wr(2'h3, 8'he2);
      rc(2'h0, 8'h90);
      host.wr(2'h3, 8'he2);
      rc(2'h0, 8'h50);
      host.rd(2'h3, 1'b0, v, o);
      chk({7'h00, o}, 8'h00);
      host.rd(2'h0, 1'b1, v, o);
      chk({7'h00, o}, 8'h00);
      $display("t_flags done");
   endtask : t_flags
   task automatic t_two;
      host.wr(2'h3, 8'hb0);
      host.wr(2'h2, 8'h02);
      host.wr(2'h2, 8'h00);
      pl(2, 2);
      cp(2, 1'b0);
      pl(2, 1);
      cp(2, 1'b1);
      host.wr(2'h2, 8'h04);
      cp(2, 1'b0);
      host.wr(2'h3, 8'he8);
      rc(2'h2, 8'h30);
      pl(2, 2);
      host.wr(2'h2, 8'h00);
      host.wr(2'h3, 8'he8);
      rc(2'h2, 8'h70);
      pl(2, 1);
      host.wr(2'h3, 8'hd8);
      pl(2, 1);
      host.wr(2'h3, 8'hc8);
      rc(2'h2, 8'h30);
      rc(2'h2, 8'h04);
      rc(2'h2, 8'h00);
      rc(2'h2, 8'h03);
      rc(2'h2, 8'h00);
      pl(2, 2);
      cp(2, 1'b0);
      pl(2, 1);
      cp(2, 1'b1);
      $display("t_two done");
   endtask : t_two
   task automatic t_mode1;
      host.wr(2'h3, 8'h52);
      cp(1, 1'b1);
      host.wr(2'h1, 8'h03);
      pl(1, 2);
      cp(1, 1'b1);
      trg(1);
      pl(1, 1);
      cp(1, 1'b0);
      host.wr(2'h1, 8'h02);
      pl(1, 2);
      cp(1, 1'b0);
      pl(1, 1);
      cp(1, 1'b1);
      trg(1);
      pl(1, 2);
      cp(1, 1'b0);
      trg(1);
      pl(1, 2);
      cp(1, 1'b0);
      pl(1, 1);
      cp(1, 1'b1);
      $display("t_mode1 done");
   endtask : t_mode1
   // ==========================================================
   // Verdict
   task automatic final_report;
      $display("Comparisons %0d, mismatches %0d", comparisons, fails);
      if (fails == 0 && comparisons > 0) begin
         $display("All tests passed");
      end else begin
         $display("Some tests failed");
      end
      $finish;
   endtask : final_report
   // Main sequence after a two-cycle reset.
   initial begin
      repeat (2) @(posedge clk);
      rst_n <= 1'b1;
      repeat (3) @(posedge clk);
      t_mode0();
      t_flags();
      t_two();
      t_mode1();
      final_report();
   end
   // Watchdog well beyond the expected run length.
   initial begin
      repeat (8000) @(posedge clk);
      fails++;
      final_report();
   end
endmodule : itm_top_bench
